// ---- core/bct_regs.svh ----
// register offsets, field positions, codes and timing figures of the capture trigger
`ifndef BCT_REGS_SVH
`define BCT_REGS_SVH
// byte offsets on the register bus
`define BCT_A_CTRL 8'h00
`define BCT_A_MODE 8'h04
`define BCT_A_TCTL 8'h08
`define BCT_A_TDAT 8'h0C
`define BCT_A_TAUX 8'h10
`define BCT_A_IDQ 8'h14
`define BCT_A_STAT 8'h18
`define BCT_A_RDIX 8'h1C
`define BCT_A_RDAT 8'h20
`define BCT_A_TIDX 8'h24
// writable bits of the MODE, TCTL, TAUX and IDQ registers, the rest read as zero
`define BCT_M_MODE 32'h0000_00FF
`define BCT_M_TCTL 32'h0003_FFFF
`define BCT_M_TAUX 32'h0FFF_0FFF
`define BCT_M_IDQ 32'h0000_3FFF
// field positions
`define BCT_F_RUN 0
`define BCT_F_STOP 1
`define BCT_F_TMODE 1:0
`define BCT_F_POS 3:2
`define BCT_F_PHASE 7:4
`define BCT_F_TCTL 17:0
`define BCT_F_TPAR 3:0
`define BCT_F_TPRB 11:4
`define BCT_F_TCNT 27:16
`define BCT_F_IQMODE 1:0
`define BCT_F_IQINI 5:2
`define BCT_F_IQTGT 9:6
`define BCT_F_IQTOP 11:10
`define BCT_F_IQAOP 13:12
`define BCT_F_CAP 0
`define BCT_F_TRG 1
`define BCT_F_WRAP 2
`define BCT_F_WPTR 31:16
// control line positions within the control vector
`define BCT_C_BSY 8
`define BCT_C_SEL 7
`define BCT_C_IO 2
// id wildcard bit
`define BCT_ID_ANY 3
// pattern element codes
`define BCT_E_LO 2'h0
`define BCT_E_HI 2'h1
`define BCT_E_X 2'h2
`define BCT_E_P 2'h3
// events kept after the trigger for each position
`define BCT_DLY_EARLY 16'h76C0
`define BCT_DLY_CENTER 16'h3E80
`define BCT_DLY_LATE 16'h0640
// sampling period and clock period in ns
`define BCT_SAMPLE_NS 20
`define BCT_CLK_NS 10
// bus responses
`define BCT_RESP_OK 2'h0
`define BCT_RESP_ERR 2'h2
`endif

// ---- core/bct_pkg.sv ----
// shared enumerations of the bus capture trigger block
package bct_pkg;
  typedef enum logic [1:0] {tm_none, tm_imm, tm_phase, tm_bits} bct_tmode_t;
  typedef enum logic [1:0] {pos_early, pos_center, pos_late} bct_pos_t;
  typedef enum logic [3:0] {
    ph_arb, ph_sel, ph_resel, ph_msgo, ph_cmd, ph_dout, ph_din, ph_stat, ph_msgi
  } bct_phase_t;
  typedef enum logic [1:0] {iq_off, iq_selresel, iq_sel, iq_resel} bct_iqmode_t;
  typedef enum logic [1:0] {op_off, op_allow, op_suppress} bct_iqopt_t;
  typedef enum logic [1:0] {cs_idle, cs_run, cs_post} bct_cstate_t;
endpackage

// ---- core/bct_idq.sv ----
// id qualifier: connection tracking and pass decisions for both paths
`timescale 1ns/1ps
`include "bct_regs.svh"
module bct_idq (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clr,
  input  wire logic                  evt,
  input  wire logic [8:0]            ctl,
  input  wire logic [7:0]            ids,
  input  wire bct_pkg::bct_iqmode_t  mode,
  input  wire logic [3:0]            init_id,
  input  wire logic [3:0]            tgt_id,
  input  wire bct_pkg::bct_iqopt_t   topt,
  input  wire bct_pkg::bct_iqopt_t   aopt,
  output logic                       trig_pass,
  output logic                       acq_pass
);
  typedef struct packed {
    logic conn_ok;
    logic linked;
  } bct_iqst_t;
  bct_iqst_t s_r;
  bct_iqst_t s_nxt;
  logic      sel_ph;
  logic      pair_ok;
  logic      kind_ok;
  logic      asr;

  function automatic logic id_hit(input logic [3:0] id, input logic [7:0] bus);
    id_hit = id[`BCT_ID_ANY] | bus[id[2:0]];
  endfunction

  function automatic logic opt_pass(input bct_pkg::bct_iqopt_t op, input logic a,
                                    input logic ok);
    case (op)
      bct_pkg::op_allow:    opt_pass = a | ok;
      bct_pkg::op_suppress: opt_pass = !a & ok;
      default:              opt_pass = 1'b1;
    endcase
  endfunction

  // every selection is inspected even when its events are dropped later
  always_comb begin
    s_nxt   = s_r;
    sel_ph  = ctl[`BCT_C_SEL] & !ctl[`BCT_C_BSY];
    pair_ok = id_hit(init_id, ids) & id_hit(tgt_id, ids);
    case (mode)
      bct_pkg::iq_sel:   kind_ok = !ctl[`BCT_C_IO];
      bct_pkg::iq_resel: kind_ok = ctl[`BCT_C_IO];
      default:           kind_ok = 1'b1;
    endcase
    // before the target answers, the bus is in arbitration or selection
    asr = !s_r.linked | ctl[`BCT_C_SEL];
    if (clr) begin
      s_nxt = bct_iqst_t'(2'h0);
    end else if (evt) begin
      if (sel_ph) begin
        s_nxt.conn_ok = pair_ok & kind_ok;
      end
      if (ctl[`BCT_C_BSY] & ctl[`BCT_C_SEL]) begin
        s_nxt.linked = 1'b1;
      end else if (!ctl[`BCT_C_BSY] & !ctl[`BCT_C_SEL]) begin
        s_nxt = bct_iqst_t'(2'h0);
      end
    end
    if (mode == bct_pkg::iq_off) begin
      trig_pass = 1'b1;
      acq_pass  = 1'b1;
    end else begin
      trig_pass = opt_pass(topt, asr, s_r.conn_ok);
      acq_pass  = opt_pass(aopt, asr, s_r.conn_ok);
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= bct_iqst_t'(2'h0);
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off;
    mode == bct_pkg::iq_off |-> trig_pass && acq_pass;
  endproperty
  a_off: assert property (p_off) else $error("qualifier off blocked an event");

  property p_selonly;
    evt && !clr && sel_ph && mode == bct_pkg::iq_sel && ctl[`BCT_C_IO] |=> !s_r.conn_ok;
  endproperty
  a_selonly: assert property (p_selonly) else $error("reselection qualified");

  property p_supp;
    mode != bct_pkg::iq_off && aopt == bct_pkg::op_suppress && ctl[`BCT_C_SEL] |-> !acq_pass;
  endproperty
  a_supp: assert property (p_supp) else $error("selection event passed");
endmodule

// ---- core/bct_top.sv ----
// trigger, id qualification and event capture buffer behind an axi4-lite slave
`timescale 1ns/1ps
`include "bct_regs.svh"
module bct_top #(
  parameter int DEPTH = 32768,
  parameter int AW    = 15,
  parameter int CW    = 12
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [8:0]  scsi_ctl,
  input  wire logic [15:0] scsi_data,
  input  wire logic [1:0]  scsi_par,
  input  wire logic [3:0]  probe_pod_inputs,
  output logic             capturing,
  output logic             triggered
);
  localparam int EW   = 31;
  localparam int DW   = 4;
  localparam int SCYC = `BCT_SAMPLE_NS / `BCT_CLK_NS;
  localparam logic [1:0] L = `BCT_E_LO;
  localparam logic [1:0] H = `BCT_E_HI;
  localparam logic [1:0] X = `BCT_E_X;
  localparam logic [1:0] P = `BCT_E_P;

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 aw_h;
    logic                 w_h;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic [31:0]          mode;
    logic [31:0]          tctl;
    logic [31:0]          tdat;
    logic [31:0]          taux;
    logic [31:0]          idq;
    logic [AW-1:0]        rdix;
    logic [AW-1:0]        wptr;
    logic [AW-1:0]        tidx;
    logic                 wrapped;
    bct_pkg::bct_cstate_t cs;
    logic [CW-1:0]        occ;
    logic [15:0]          post;
    logic [DW-1:0]        div;
    logic [EW-1:0]        last;
    logic                 have_last;
    logic                 capturing;
    logic                 triggered;
  } bct_st_t;

  bct_st_t              s_r;
  bct_st_t              s_nxt;
  logic [EW-1:0]        mem [DEPTH];
  logic [EW-1:0]        cur;
  logic [2*EW-1:0]      tpat;
  logic [17:0]          ctlp;
  logic [15:0]          lim;
  logic [31:0]          rword;
  logic                 rerr;
  logic                 tick;
  logic                 is_evt;
  logic                 trig_pass;
  logic                 acq_pass;
  logic                 store;
  logic                 hit;
  logic                 wr_go;
  logic                 start;
  logic                 stop;
  bct_pkg::bct_tmode_t  tmode;
  bct_pkg::bct_pos_t    tpos;

  // one pattern element against the current and previous event
  function automatic logic el_ok(input logic [1:0] c, input logic cv, input logic pv);
    case (c)
      `BCT_E_LO: el_ok = !cv;
      `BCT_E_HI: el_ok = cv;
      `BCT_E_P:  el_ok = cv & !pv;
      default:   el_ok = 1'b1;
    endcase
  endfunction

  // every element must hold, don't-care elements always do
  function automatic logic pat_ok(input logic [2*EW-1:0] p, input logic [EW-1:0] c,
                                  input logic [EW-1:0] v);
    pat_ok = 1'b1;
    for (int i = 0; i < EW; i++) begin
      pat_ok = pat_ok & el_ok(p[2*i +: 2], c[i], v[i]);
    end
  endfunction

  // fixed control patterns: bsy sel atn req ack cd io msg rst
  function automatic logic [17:0] ph_pat(input bct_pkg::bct_phase_t ph);
    case (ph)
      bct_pkg::ph_arb:   ph_pat = {H, L, L, L, L, L, L, L, L};
      bct_pkg::ph_sel:   ph_pat = {L, H, X, X, X, X, L, X, L};
      bct_pkg::ph_resel: ph_pat = {L, H, X, X, X, X, H, X, L};
      bct_pkg::ph_msgo:  ph_pat = {H, L, X, L, P, H, L, H, L};
      bct_pkg::ph_cmd:   ph_pat = {H, L, X, L, P, H, L, L, L};
      bct_pkg::ph_dout:  ph_pat = {H, L, X, P, P, L, L, L, L};
      bct_pkg::ph_din:   ph_pat = {H, L, X, P, P, L, H, L, L};
      bct_pkg::ph_stat:  ph_pat = {H, L, X, P, L, H, H, L, L};
      bct_pkg::ph_msgi:  ph_pat = {H, L, X, P, L, H, H, H, L};
      default:           ph_pat = {9{X}};
    endcase
  endfunction

  // byte-lane merge of a register write
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = b[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // stored events that end the capture once triggered
  function automatic logic [15:0] stop_at(input bct_pkg::bct_tmode_t m,
                                          input bct_pkg::bct_pos_t p);
    if (m == bct_pkg::tm_imm) begin
      stop_at = 16'(DEPTH);
    end else begin
      case (p)
        bct_pkg::pos_early:  stop_at = `BCT_DLY_EARLY;
        bct_pkg::pos_center: stop_at = `BCT_DLY_CENTER;
        default:             stop_at = `BCT_DLY_LATE;
      endcase
    end
  endfunction

  // decoded settings and the sample under test
  assign tmode = bct_pkg::bct_tmode_t'(s_r.mode[`BCT_F_TMODE]);
  assign tpos  = bct_pkg::bct_pos_t'(s_r.mode[`BCT_F_POS]);
  assign cur   = {scsi_ctl, scsi_data, scsi_par, probe_pod_inputs};
  assign tick  = (s_r.div == DW'(0));
  // a sample is an event when it is the first since reset or some line moved since the last one
  assign is_evt = tick & (!s_r.have_last | (cur != s_r.last));
  // bit mode may also carry illegal bus states; the rising code is left to software
  assign ctlp = (tmode == bct_pkg::tm_phase) ?
                ph_pat(bct_pkg::bct_phase_t'(s_r.mode[`BCT_F_PHASE])) :
                s_r.tctl[`BCT_F_TCTL];
  assign tpat = {ctlp, s_r.tdat, s_r.taux[`BCT_F_TPAR], s_r.taux[`BCT_F_TPRB]};
  assign lim  = stop_at(tmode, tpos);
  assign store = is_evt & (s_r.cs != bct_pkg::cs_idle) & acq_pass;
  assign hit   = is_evt & (s_r.cs == bct_pkg::cs_run) & trig_pass &
                 ((tmode == bct_pkg::tm_phase) | (tmode == bct_pkg::tm_bits)) &
                 pat_ok(tpat, cur, s_r.last);
  // control writes act in the cycle the write completes
  assign wr_go = s_r.aw_h & s_r.w_h & !s_r.bvalid;
  assign start = wr_go & (s_r.awaddr == `BCT_A_CTRL) & s_r.wstrb[0] &
                 s_r.wdata[`BCT_F_RUN];
  assign stop  = wr_go & (s_r.awaddr == `BCT_A_CTRL) & s_r.wstrb[0] &
                 s_r.wdata[`BCT_F_STOP];

  bct_idq u_idq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clr       (start),
    .evt       (is_evt),
    .ctl       (scsi_ctl),
    .ids       (scsi_data[7:0]),
    .mode      (bct_pkg::bct_iqmode_t'(s_r.idq[`BCT_F_IQMODE])),
    .init_id   (s_r.idq[`BCT_F_IQINI]),
    .tgt_id    (s_r.idq[`BCT_F_IQTGT]),
    .topt      (bct_pkg::bct_iqopt_t'(s_r.idq[`BCT_F_IQTOP])),
    .aopt      (bct_pkg::bct_iqopt_t'(s_r.idq[`BCT_F_IQAOP])),
    .trig_pass (trig_pass),
    .acq_pass  (acq_pass)
  );

  // read data mux, unmapped offsets answer with an error
  always_comb begin
    rword = 32'h0000_0000;
    rerr  = 1'b0;
    case (s_axi_araddr)
      `BCT_A_CTRL: rword = 32'h0000_0000;
      `BCT_A_MODE: rword = s_r.mode;
      `BCT_A_TCTL: rword = s_r.tctl;
      `BCT_A_TDAT: rword = s_r.tdat;
      `BCT_A_TAUX: rword = s_r.taux;
      `BCT_A_IDQ:  rword = s_r.idq;
      `BCT_A_STAT: begin
        rword[`BCT_F_CAP]  = s_r.capturing;
        rword[`BCT_F_TRG]  = s_r.triggered;
        rword[`BCT_F_WRAP] = s_r.wrapped;
        rword[`BCT_F_WPTR] = 16'(s_r.wptr);
      end
      `BCT_A_RDIX: rword = 32'(s_r.rdix);
      `BCT_A_RDAT: rword = 32'(mem[s_r.rdix]);
      `BCT_A_TIDX: rword = 32'(s_r.tidx);
      default:     rerr  = 1'b1;
    endcase
  end

  // next state of bus slave, sampler, trigger and buffer pointer
  always_comb begin
    s_nxt     = s_r;
    s_nxt.div = tick ? DW'(SCYC - 1) : DW'(s_r.div - 1'b1);
    // address and data are caught independently, in either order
    if (s_axi_awvalid & s_r.awready) begin
      s_nxt.aw_h   = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_r.wready) begin
      s_nxt.w_h   = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid & s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_h   = 1'b0;
      s_nxt.w_h    = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `BCT_RESP_OK;
      case (s_r.awaddr)
        `BCT_A_CTRL, `BCT_A_STAT, `BCT_A_RDAT, `BCT_A_TIDX: ;
        `BCT_A_MODE: s_nxt.mode = wmerge(s_r.mode, s_r.wdata, s_r.wstrb) & `BCT_M_MODE;
        `BCT_A_TCTL: s_nxt.tctl = wmerge(s_r.tctl, s_r.wdata, s_r.wstrb) & `BCT_M_TCTL;
        `BCT_A_TDAT: s_nxt.tdat = wmerge(s_r.tdat, s_r.wdata, s_r.wstrb);
        `BCT_A_TAUX: s_nxt.taux = wmerge(s_r.taux, s_r.wdata, s_r.wstrb) & `BCT_M_TAUX;
        `BCT_A_IDQ:  s_nxt.idq = wmerge(s_r.idq, s_r.wdata, s_r.wstrb) & `BCT_M_IDQ;
        `BCT_A_RDIX: s_nxt.rdix = AW'(s_r.wdata);
        default:     s_nxt.bresp = `BCT_RESP_ERR;
      endcase
    end
    if (s_axi_arvalid & s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rword;
      s_nxt.rresp  = rerr ? `BCT_RESP_ERR : `BCT_RESP_OK;
    end else if (s_r.rvalid & s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // the reference for change detection moves on every event, run or not
    if (is_evt) begin
      s_nxt.last      = cur;
      s_nxt.have_last = 1'b1;
    end
    // ring pointer; the oldest event is lost once the ring is full
    if (store) begin
      if (s_r.wptr == AW'(DEPTH - 1)) begin
        s_nxt.wptr    = AW'(0);
        s_nxt.wrapped = 1'b1;
      end else begin
        s_nxt.wptr = AW'(s_r.wptr + 1'b1);
      end
    end
    case (s_r.cs)
      bct_pkg::cs_run: begin
        if (hit) begin
          s_nxt.occ = CW'(s_r.occ + 1'b1);
          if (CW'(s_r.occ + 1'b1) >= CW'(s_r.taux[`BCT_F_TCNT])) begin
            s_nxt.cs        = bct_pkg::cs_post;
            s_nxt.triggered = 1'b1;
            s_nxt.tidx      = s_r.wptr;
            s_nxt.post      = 16'h0000;
          end
        end
      end
      bct_pkg::cs_post: begin
        // only events stored after the trigger count toward the stop
        if (store) begin
          s_nxt.post = 16'(s_r.post + 1'b1);
          if (16'(s_r.post + 1'b1) == lim) begin
            s_nxt.cs = bct_pkg::cs_idle;
          end
        end
      end
      default: ;
    endcase
    // software stop ends any capture; an early stop keeps the whole buffer
    if (stop) begin
      s_nxt.cs = bct_pkg::cs_idle;
    end
    // start wins over stop when both bits are written together
    if (start) begin
      s_nxt.wptr      = AW'(0);
      s_nxt.wrapped   = 1'b0;
      s_nxt.occ       = CW'(0);
      s_nxt.post      = 16'h0000;
      s_nxt.tidx      = AW'(0);
      s_nxt.triggered = (tmode == bct_pkg::tm_imm);
      s_nxt.cs        = (tmode == bct_pkg::tm_imm) ? bct_pkg::cs_post : bct_pkg::cs_run;
    end
    s_nxt.capturing = (s_nxt.cs != bct_pkg::cs_idle);
    s_nxt.awready   = !s_nxt.aw_h & !s_nxt.bvalid;
    s_nxt.wready    = !s_nxt.w_h & !s_nxt.bvalid;
    s_nxt.arready   = !s_nxt.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= {$bits(bct_st_t){1'b0}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // capture storage, no reset so it maps onto plain flops without a reset tree
  always_ff @(posedge aclk) begin
    if (store) begin
      mem[s_r.wptr] <= cur;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign capturing     = s_r.capturing;
  assign triggered     = s_r.triggered;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_start;
    start |=> capturing && s_r.cs != bct_pkg::cs_idle;
  endproperty
  a_start: assert property (p_start) else $error("run did not start capture");

  property p_clear;
    start |=> s_r.occ == CW'(0) && s_r.post == 16'h0000 && s_r.wptr == AW'(0);
  endproperty
  a_clear: assert property (p_clear) else $error("counters not cleared on run");

  property p_wrap;
    store && !start && s_r.wptr == AW'(DEPTH - 1) |=> s_r.wptr == AW'(0) && s_r.wrapped;
  endproperty
  a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

  property p_none;
    s_r.cs == bct_pkg::cs_run && tmode == bct_pkg::tm_none && !start |=> !s_r.triggered;
  endproperty
  a_none: assert property (p_none) else $error("no-trigger mode triggered");

  property p_imm;
    start && tmode == bct_pkg::tm_imm |=>
      s_r.triggered && s_r.cs == bct_pkg::cs_post && s_r.tidx == AW'(0);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate trigger not at start");

  property p_occ;
    !hit && !start |=> $stable(s_r.occ);
  endproperty
  a_occ: assert property (p_occ) else $error("occurrence moved without a match");

  property p_end;
    s_r.cs == bct_pkg::cs_post && store && !start && 16'(s_r.post + 1'b1) == lim |=>
      s_r.cs == bct_pkg::cs_idle && !capturing;
  endproperty
  a_end: assert property (p_end) else $error("capture ran past its stop point");

  property p_tick;
    // the divider sits at zero through reset, so the edge of release is left out
    tick && $past(aresetn) |=> !tick ##1 tick;
  endproperty
  a_tick: assert property (p_tick) else $error("sampling is not every 20 ns");
endmodule

// ---- sim/bct_bus_model.sv ----
// bus side model: one new bus state per step request
`timescale 1ns/1ps
module bct_bus_model (
  input  wire logic       aclk,
  input  wire logic       step,
  input  wire logic [8:0] ctl_in,
  input  wire logic [7:0] ids_in,
  output logic [8:0]      scsi_ctl,
  output logic [15:0]     scsi_data,
  output logic [1:0]      scsi_par,
  output logic [3:0]      probe_pod_inputs
);
  logic [15:0] cnt_r = 16'h0000;
  // a state is held until the next step, long enough for four samples
  always_ff @(posedge aclk) begin
    if (step) cnt_r <= cnt_r + 16'h0001;
  end
  // control lines follow the bench; a nonzero id byte overrides the data lines
  assign scsi_ctl = ctl_in;
  assign scsi_data = (ids_in != 8'h00) ? {8'h00, ids_in} : cnt_r;
  assign scsi_par = cnt_r[1:0];
  assign probe_pod_inputs = cnt_r[5:2];
endmodule

// ---- sim/bct_top_tb.sv ----
// self-checking bench of the capture trigger block
`timescale 1ns/1ps
`include "bct_regs.svh"
module bct_top_tb;
  logic aclk = 0, aresetn = 0, step = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, w0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, capturing, triggered;
  logic [1:0] bresp, rresp, r;
  logic [8:0] ctl;
  logic [15:0] dat;
  logic [1:0] par;
  logic [3:0] prb;
  logic [8:0] ctl_in = 9'h100;
  logic [7:0] ids_in = 8'h00;
  int error_cnt = 0, tests_run = 0, m;
  typedef struct {logic [7:0] a; logic [31:0] exp; logic [1:0] rsp;} row_t;
  row_t rows[6] = '{'{8'h04, 32'h0000_00FF, 2'h0}, '{8'h08, 32'h0003_FFFF, 2'h0},
    '{8'h0C, 32'hFFFF_FFFF, 2'h0}, '{8'h10, 32'h0FFF_0FFF, 2'h0},
    '{8'h14, 32'h0000_3FFF, 2'h0}, '{8'h28, 32'h0000_0000, 2'h2}};
  bct_top #(.DEPTH(64), .AW(6), .CW(12)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scsi_ctl(ctl), .scsi_data(dat), .scsi_par(par), .probe_pod_inputs(prb),
    .capturing(capturing), .triggered(triggered));
  bct_bus_model bus (.aclk(aclk), .step(step), .ctl_in(ctl_in), .ids_in(ids_in),
    .scsi_ctl(ctl), .scsi_data(dat), .scsi_par(par), .probe_pod_inputs(prb));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    v = rdata; e = rresp; rready <= 0;
  endtask
  // n bus state changes, each followed by time for sampling and evaluation
  task ev(input int n);
    repeat (n) begin
      @(posedge aclk); step <= 1;
      @(posedge aclk); step <= 0;
      repeat (6) @(posedge aclk);
    end
  endtask
  // one bus state set by the bench, held long enough to be sampled
  task drive_bus(input logic [8:0] c, input logic [7:0] i);
    @(posedge aclk);
    ctl_in <= c;
    ids_in <= i;
    repeat (7) @(posedge aclk);
  endtask
  // selection then reselection of ids 0 and 1 under one qualifier setting
  task idrun(input logic [31:0] q, input logic [8:0] first);
    wr(`BCT_A_IDQ, q);
    wr(`BCT_A_CTRL, 32'h1);
    drive_bus(9'h080, 8'h03);
    drive_bus(9'h180, 8'h03);
    drive_bus(9'h100, 8'h00);
    ev(2);
    drive_bus(9'h000, 8'h00);
    drive_bus(9'h084, 8'h03);
    drive_bus(9'h184, 8'h03);
    drive_bus(9'h104, 8'h00);
    ev(2);
    rd(`BCT_A_STAT, d, r);
    chk(d[31:16], 16'h0004);
    wr(`BCT_A_RDIX, 32'h0);
    rd(`BCT_A_RDAT, d, r);
    chk(d[30:22], first);
    wr(`BCT_A_CTRL, 32'h2);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    // reset value, writable mask, unmapped refusal
    foreach (rows[i]) begin
      rd(rows[i].a, d, r); chk(d, 32'h0);
      wr(rows[i].a, 32'hFFFF_FFFF);
      rd(rows[i].a, d, r); chk(d, rows[i].exp); chk(r, rows[i].rsp);
    end
    wr(`BCT_A_IDQ, 32'h0);
    // no trigger: run, wrap past the depth, never trigger, software stop
    wr(`BCT_A_MODE, 32'h0);
    rd(`BCT_A_STAT, w0, r);
    wr(`BCT_A_CTRL, 32'h1); ev(70);
    rd(`BCT_A_STAT, d, r);
    chk(d[2:0], 3'h5);
    chk(d[31:16] - w0[31:16] & 16'h003F, 16'h0006);
    wr(`BCT_A_RDIX, (d[31:16] - 1) & 32'h3F);
    rd(`BCT_A_RDAT, d, r);
    chk(d[30:0], {ctl, dat, par, prb});
    wr(`BCT_A_CTRL, 32'h2); chk(capturing, 1'b0);
    // immediate: trigger at run, stop after a full buffer
    wr(`BCT_A_MODE, 32'h1); wr(`BCT_A_CTRL, 32'h1);
    chk(triggered, 1'b1); ev(66);
    chk(capturing, 1'b0); rd(`BCT_A_TIDX, d, r); chk(d, 32'h0);
    // bit mode, late position, count of two on data bit 0 high
    wr(`BCT_A_TCTL, 32'h0002_AAAA); wr(`BCT_A_TDAT, 32'hAAAA_AAA9);
    wr(`BCT_A_TAUX, 32'h0002_0AAA); wr(`BCT_A_MODE, 32'h0B);
    wr(`BCT_A_CTRL, 32'h1); chk(triggered, 1'b0); m = 0;
    repeat (5) begin
      ev(1);
      if (dat[0]) m++;
      chk(triggered, m >= 2);
    end
    chk(capturing, 1'b1);
    wr(`BCT_A_CTRL, 32'h2);
    // id qualifier: selection-only pair with suppress, then wrong pair with allow
    wr(`BCT_A_MODE, 32'h0);
    idrun(32'h0000_2042, 9'h100);
    idrun(32'h0000_1049, 9'h080);
    // phase mode on selection: a reselection must not match
    wr(`BCT_A_IDQ, 32'h0);
    wr(`BCT_A_TDAT, 32'hAAAA_AAAA);
    wr(`BCT_A_TAUX, 32'h0001_0AAA);
    wr(`BCT_A_MODE, 32'h1A);
    wr(`BCT_A_CTRL, 32'h1);
    drive_bus(9'h084, 8'h03);
    chk(triggered, 1'b0);
    drive_bus(9'h080, 8'h03);
    chk(triggered, 1'b1);
    // reset in mid-capture clears state and settings
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk(capturing, 1'b0);
    chk(triggered, 1'b0);
    rd(`BCT_A_MODE, d, r);
    chk(d, 32'h0);
    results();
  end
endmodule
